// *** include/pas_pkg.sv ***
package pas_pkg;
   // register bus geometry and map
   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 32;
   localparam logic [7:0]  REG_CTRL_OFS = 8'h00;
   localparam logic [7:0]  REG_TEST_OFS = 8'h08;
   localparam logic [7:0]  REG_STAT_OFS = 8'h0C;

   // control register fields
   localparam int          CTRL_AUX_BIT  = 4;
   localparam int          CTRL_TPC_BIT  = 7;
   localparam int          CTRL_LOW_SUPPLY_LOCKOUT_BIT = 10;
   localparam logic        AUX_FUNC_RST  = 1'b1;

   // test register fields
   localparam int          TSEL_W       = 3;
   localparam int          TEST_ATM_LSB = 2;
   localparam int          TEST_DTM_LSB = 5;
   localparam logic [2:0]  TSEL_OFF     = 3'h0;
   localparam logic [2:0]  DTM_SD_MODE  = 3'h4;
   localparam logic [2:0]  DTM_AGC      = 3'h1;
   localparam logic [2:0]  DTM_MAIN_DIV = 3'h2;
   localparam logic [2:0]  DTM_REF_DIV  = 3'h3;

   // status register fields
   localparam int          STAT_STATE_LSB = 0;
   localparam int          STAT_PA        = 4;
   localparam int          STAT_LOCK      = 5;
   localparam int          STAT_LOCKOUT   = 6;
   localparam int          STAT_AUX_FUNC  = 7;
   localparam int          STAT_TPC       = 8;
   localparam int          STAT_AUX_PIN   = 9;
   localparam int          STAT_RX_MODE   = 10;
   localparam int          STAT_SHIFT     = 11;

   // aux pin routing codes
   localparam logic [1:0]  AUX_ROUTE_FILTER = 2'h0;
   localparam logic [1:0]  AUX_ROUTE_PWR    = 2'h1;
   localparam logic [1:0]  AUX_ROUTE_TEST   = 2'h2;

   // timing, times in microseconds
   localparam real         CLK_MHZ     = 250.0;
   localparam real         T_SHIFT_US  = 6.5;
   localparam real         T_SETTLE_US = 70.0;
   localparam real         T_DROP_US   = 0.1;
   localparam real         T_PA_ON_US  = 1.0;
   localparam int          SHIFT_CYC   = int'($ceil(T_SHIFT_US * CLK_MHZ));
   localparam int          SETTLE_CYC  = int'($ceil(T_SETTLE_US * CLK_MHZ));
   localparam int          DROP_MAX_CYC = int'($floor(T_DROP_US * CLK_MHZ));
   localparam int          PA_ON_CYC   = int'($ceil(T_PA_ON_US * CLK_MHZ));

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_TX_WAIT,
      ST_TX_ON,
      ST_RX_SHIFT,
      ST_RX_SETTLE,
      ST_RX
   } pas_state_e;
endpackage

// *** src/pas_sequencer.sv ***
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pas_sequencer
   import pas_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
   parameter int unsigned PA_ON_CYCLES  = PA_ON_CYC,
   parameter int          CNT_W         = $clog2(SETTLE_CYCLES + 1)
) (
   // clock and reset
   input  wire logic                          core_clk_in,
   input  wire logic                          rst_in,
   // register port
   input  wire logic [pas_pkg::ADDR_W-1:0]    reg_addr_in,
   input  wire logic [pas_pkg::DATA_W-1:0]    reg_wdata_in,
   input  wire logic                          reg_wr_in,
   input  wire logic                          reg_rd_in,
   output logic      [pas_pkg::DATA_W-1:0]    reg_rdata_out,
   // pins from outside the clock domain
   input  wire logic                          receive_on_ctrl_in,
   input  wire logic                          synth_lock_in,
   input  wire logic                          supply_low_in,
   input  wire logic                          aux_analog_pin_in,
   // internal sources on this clock
   input  wire logic                          rx_data_in,
   input  wire logic                          agc_state_in,
   input  wire logic                          main_div_in,
   input  wire logic                          ref_div_in,
   input  wire logic                          sd_lsb_in,
   input  wire logic                          sd_msb_in,
   // amplifier and data pins
   output logic                               pa_enable_out,
   output logic                               dout_out,
   // aux open-drain pin and analog routing
   output logic                               aux_analog_pin_out,
   output logic                               aux_analog_pin_oe_out,
   output logic      [1:0]                    aux_route_out,
   output logic      [pas_pkg::TSEL_W-1:0]    analog_test_select_out,
   // synthesizer sequencing
   output logic                               synth_shift_rx_out,
   output logic                               rx_mode_out
);
   localparam int DROP_LIM = DROP_MAX_CYC;

   logic [3:0]        pins_sync;
   logic              receive_on_ctrl_s;
   logic              lock_s;
   logic              low_s;
   logic              auxpin_s;
   logic              receive_on_ctrl_prev_ff;
   logic              receive_on_ctrl_rise;
   logic              receive_on_ctrl_fall;
   logic              tmr_load;
   logic [CNT_W-1:0]  tmr_val;
   logic              tmr_done;
   pas_state_e        state_ff;
   pas_state_e        nxt_state;
   logic              aux_func_ff;
   logic              tpc_ff;
   logic              low_supply_lockout_ff;
   logic [2:0]        atm_ff;
   logic [2:0]        dtm_ff;
   logic              aux_func_app_ff;
   logic              tpc_app_ff;
   logic              lockout_ff;
   logic              nxt_pa;
   logic              nxt_dout;
   logic [DATA_W-1:0] nxt_rdata;
   logic [DATA_W-1:0] stat_word;
   int unsigned       elapsed_ff;

   pas_sync #(
      .W(4)
   ) u_sync (
      .core_clk_in(core_clk_in),
      .rst_in     (rst_in),
      .async_in   ({aux_analog_pin_in, supply_low_in, synth_lock_in, receive_on_ctrl_in}),
      .sync_out   (pins_sync)
   );

   assign receive_on_ctrl_s   = pins_sync[0];
   assign lock_s   = pins_sync[1];
   assign low_s    = pins_sync[2];
   assign auxpin_s = pins_sync[3];
   assign receive_on_ctrl_rise = receive_on_ctrl_s && !receive_on_ctrl_prev_ff;
   assign receive_on_ctrl_fall = !receive_on_ctrl_s && receive_on_ctrl_prev_ff;

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         receive_on_ctrl_prev_ff <= 1'b0;
      end else begin
         receive_on_ctrl_prev_ff <= receive_on_ctrl_s;
      end
   end

   // one timer serves every phase; receive loads the shift leg then the rest of settle
   always_comb begin
      tmr_load = 1'b0;
      tmr_val  = '0;
      if (receive_on_ctrl_rise) begin
         tmr_load = 1'b1;
         tmr_val  = CNT_W'(SHIFT_CYC);
      end else if (receive_on_ctrl_fall) begin
         tmr_load = 1'b1;
         tmr_val  = CNT_W'(PA_ON_CYCLES);
      end else if (state_ff == ST_RX_SHIFT && tmr_done) begin
         tmr_load = 1'b1;
         tmr_val  = CNT_W'(SETTLE_CYCLES - SHIFT_CYC);
      end
   end

   pas_timer #(
      .W(CNT_W)
   ) u_timer (
      .core_clk_in(core_clk_in),
      .rst_in     (rst_in),
      .load_in    (tmr_load),
      .load_val_in(tmr_val),
      .done_out   (tmr_done)
   );

   always_comb begin
      nxt_state = state_ff;
      if (receive_on_ctrl_rise) begin
         nxt_state = ST_RX_SHIFT;
      end else if (receive_on_ctrl_fall) begin
         nxt_state = ST_TX_WAIT;
      end else begin
         unique case (state_ff)
            ST_IDLE:      nxt_state = ST_IDLE;
            ST_TX_WAIT:   nxt_state = tmr_done ? ST_TX_ON : ST_TX_WAIT;
            ST_TX_ON:     nxt_state = ST_TX_ON;
            ST_RX_SHIFT:  nxt_state = tmr_done ? ST_RX_SETTLE : ST_RX_SHIFT;
            ST_RX_SETTLE: nxt_state = tmr_done ? ST_RX : ST_RX_SETTLE;
            ST_RX:        nxt_state = ST_RX;
            default:      nxt_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // synthesizer sequencing outputs follow the receive legs
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         synth_shift_rx_out <= 1'b0;
         rx_mode_out        <= 1'b0;
      end else begin
         synth_shift_rx_out <= (nxt_state == ST_RX_SETTLE) || (nxt_state == ST_RX);
         rx_mode_out        <= (nxt_state == ST_RX);
      end
   end

   // register writes; aux mode and power control reach the pins only at the next slot start, lockout and test settings at once
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         aux_func_ff <= AUX_FUNC_RST;
         tpc_ff      <= 1'b0;
         low_supply_lockout_ff     <= 1'b0;
         atm_ff      <= TSEL_OFF;
         dtm_ff      <= TSEL_OFF;
      end else if (reg_wr_in) begin
         if (reg_addr_in == REG_CTRL_OFS) begin
            aux_func_ff <= reg_wdata_in[CTRL_AUX_BIT];
            tpc_ff      <= reg_wdata_in[CTRL_TPC_BIT];
            low_supply_lockout_ff     <= reg_wdata_in[CTRL_LOW_SUPPLY_LOCKOUT_BIT];
         end
         if (reg_addr_in == REG_TEST_OFS) begin
            atm_ff <= reg_wdata_in[TEST_ATM_LSB +: TSEL_W];
            dtm_ff <= reg_wdata_in[TEST_DTM_LSB +: TSEL_W];
         end
      end
   end

   // aux mode is deferred to the start of the next transmit slot
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         aux_func_app_ff <= AUX_FUNC_RST;
         tpc_app_ff      <= 1'b0;
      end else if (receive_on_ctrl_fall) begin
         aux_func_app_ff <= aux_func_ff;
         tpc_app_ff      <= tpc_ff;
      end
   end

   // low-supply latch; a set in the rise cycle wins over the clear
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         lockout_ff <= 1'b0;
      end else if (low_supply_lockout_ff && low_s) begin
         lockout_ff <= 1'b1;
      end else if (receive_on_ctrl_rise) begin
         lockout_ff <= 1'b0;
      end
   end

   // enable pin source; test mode four takes the pin away from amplifier control
   always_comb begin
      nxt_pa = ((state_ff == ST_TX_ON) || (state_ff == ST_TX_WAIT && tmr_done))
               && lock_s
               && !(low_supply_lockout_ff && low_s) && !lockout_ff
               && !receive_on_ctrl_rise && !receive_on_ctrl_s;
      if (dtm_ff == DTM_SD_MODE) begin
         nxt_pa = sd_lsb_in;
      end
   end

   always_comb begin
      unique case (dtm_ff)
         DTM_AGC:      nxt_dout = agc_state_in;
         DTM_MAIN_DIV: nxt_dout = main_div_in;
         DTM_REF_DIV:  nxt_dout = ref_div_in;
         DTM_SD_MODE:  nxt_dout = sd_msb_in;
         default:      nxt_dout = rx_data_in;
      endcase
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pa_enable_out <= 1'b0;
         dout_out      <= 1'b0;
      end else begin
         pa_enable_out <= nxt_pa;
         dout_out      <= nxt_dout;
      end
   end

   // aux pin: open drain only drives low; analog test overrides both aux functions, routing to test and releasing the pin
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         aux_analog_pin_out     <= 1'b0;
         aux_analog_pin_oe_out  <= 1'b0;
         aux_route_out          <= AUX_ROUTE_FILTER;
         analog_test_select_out <= TSEL_OFF;
      end else begin
         aux_analog_pin_out     <= 1'b0;
         aux_analog_pin_oe_out  <= (atm_ff == TSEL_OFF) && !aux_func_app_ff && tpc_app_ff;
         analog_test_select_out <= atm_ff;
         if (atm_ff != TSEL_OFF) begin
            aux_route_out <= AUX_ROUTE_TEST;
         end else if (aux_func_app_ff) begin
            aux_route_out <= AUX_ROUTE_FILTER;
         end else begin
            aux_route_out <= AUX_ROUTE_PWR;
         end
      end
   end

   always_comb begin
      stat_word = '0;
      stat_word[STAT_STATE_LSB +: 3] = state_ff;
      stat_word[STAT_PA]       = pa_enable_out;
      stat_word[STAT_LOCK]     = lock_s;
      stat_word[STAT_LOCKOUT]  = lockout_ff;
      stat_word[STAT_AUX_FUNC] = aux_func_app_ff;
      stat_word[STAT_TPC]      = tpc_app_ff;
      stat_word[STAT_AUX_PIN]  = auxpin_s;
      stat_word[STAT_RX_MODE]  = rx_mode_out;
      stat_word[STAT_SHIFT]    = synth_shift_rx_out;
   end

   // unmapped reads return zero
   always_comb begin
      nxt_rdata = '0;
      if (reg_addr_in == REG_CTRL_OFS) begin
         nxt_rdata[CTRL_AUX_BIT]  = aux_func_ff;
         nxt_rdata[CTRL_TPC_BIT]  = tpc_ff;
         nxt_rdata[CTRL_LOW_SUPPLY_LOCKOUT_BIT] = low_supply_lockout_ff;
      end else if (reg_addr_in == REG_TEST_OFS) begin
         nxt_rdata[TEST_ATM_LSB +: TSEL_W] = atm_ff;
         nxt_rdata[TEST_DTM_LSB +: TSEL_W] = dtm_ff;
      end else if (reg_addr_in == REG_STAT_OFS) begin
         nxt_rdata = stat_word;
      end
   end

   // read data stands for one cycle only
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= '0;
      end else begin
         reg_rdata_out <= reg_rd_in ? nxt_rdata : '0;
      end
   end

   // helper: cycles since the last receive-on edge, for the checks below
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         elapsed_ff <= 0;
      end else if (receive_on_ctrl_rise || receive_on_ctrl_fall) begin
         elapsed_ff <= 0;
      end else if (elapsed_ff != 32'hFFFF_FFFF) begin
         elapsed_ff <= elapsed_ff + 1;
      end
   end

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   a_pa_only_tx: assert property (
      pa_enable_out && dtm_ff != DTM_SD_MODE && $past(dtm_ff) != DTM_SD_MODE
      |-> $past(state_ff == ST_TX_ON || state_ff == ST_TX_WAIT) && !receive_on_ctrl_prev_ff)
      else $error("enable high outside a transmit slot");
   a_pa_no_lock: assert property (
      !lock_s && dtm_ff != DTM_SD_MODE |=> !pa_enable_out)
      else $error("enable high without lock");
   a_aux_defer: assert property (
      !receive_on_ctrl_fall |=> $stable(aux_func_app_ff) && $stable(tpc_app_ff))
      else $error("aux mode changed outside slot start");
   a_aux_capture: assert property (
      receive_on_ctrl_fall |=> aux_func_app_ff == $past(aux_func_ff) && tpc_app_ff == $past(tpc_ff))
      else $error("aux mode not captured at slot start");
   a_pa_drop: assert property (
      $rose(receive_on_ctrl_in) ##0 (dtm_ff != DTM_SD_MODE)[*4]
      |-> ##[0:DROP_LIM] !pa_enable_out)
      else $error("enable not dropped after receive-on rise");
   a_shift_time: assert property (
      $rose(synth_shift_rx_out) |-> elapsed_ff == SHIFT_CYC)
      else $error("frequency shift at wrong time");
   a_rx_time: assert property (
      $rose(rx_mode_out) |-> elapsed_ff == SETTLE_CYCLES && synth_shift_rx_out)
      else $error("receive mode at wrong time");
   a_test_route: assert property (
      atm_ff != TSEL_OFF |=> aux_route_out == AUX_ROUTE_TEST && !aux_analog_pin_oe_out)
      else $error("analog test not routed");
   a_pa_delay: assert property (
      $rose(pa_enable_out) && $past(dtm_ff) != DTM_SD_MODE |-> elapsed_ff >= PA_ON_CYCLES)
      else $error("enable rose before the slot delay");
   a_od_drive: assert property (
      aux_analog_pin_oe_out |-> !aux_analog_pin_out && $past(tpc_app_ff && !aux_func_app_ff))
      else $error("open drain driven without power control");
   a_lockout_kill: assert property (
      lockout_ff && dtm_ff != DTM_SD_MODE |=> !pa_enable_out)
      else $error("enable high under supply lockout");
   a_dtm_pa: assert property (
      dtm_ff == DTM_SD_MODE |=> pa_enable_out == $past(sd_lsb_in))
      else $error("enable pin not in digital test");

   c_pa_on: cover property ($rose(pa_enable_out) && dtm_ff == TSEL_OFF);
   c_rx_full: cover property ($rose(rx_mode_out));
   c_aux_pwr: cover property ($rose(aux_analog_pin_oe_out));
   c_lockout: cover property ($rose(lockout_ff));
endmodule
`default_nettype wire

// *** src/pas_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pas_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         core_clk_in,
   input  wire logic         rst_in,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_ff;

   // first stage feeds only the second
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_ff  <= '0;
         sync_out <= '0;
      end else begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// *** src/pas_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module pas_timer #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         core_clk_in,
   input  wire logic         rst_in,
   // control
   input  wire logic         load_in,
   input  wire logic [W-1:0] load_val_in,
   output logic              done_out
);
   logic [W-1:0] cnt_ff;

   // done in the cycle the count reaches one; the caller gives its own loads priority,
   // gating done by load here would close a loop through the caller's reload path
   assign done_out = (cnt_ff == W'(1));

   // a load overrides a running count
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_ff <= '0;
      end else if (load_in) begin
         cnt_ff <= load_val_in;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - W'(1);
      end
   end
endmodule
`default_nettype wire

// *** test/pas_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// baseband controller, synthesizer lock and supply monitor as seen from the pins
module pas_far_model (
   // clock for pacing only, the pins themselves are asynchronous
   input  wire logic clk_in,
   // open-drain aux pin as driven by the block
   input  wire logic aux_oe_in,
   input  wire logic aux_drv_in,
   // pins toward the block
   output logic      receive_on_ctrl_out,
   output logic      lock_out,
   output logic      supply_low_out,
   output wire logic aux_pin_out
);
   initial begin
      receive_on_ctrl_out       = 1'b1;
      lock_out       = 1'b1;
      supply_low_out = 1'b0;
   end

   // board pull-up: a released pin reads high, never the last driven level
   assign aux_pin_out = aux_oe_in ? aux_drv_in : 1'b1;

   // pin 0 receive-on, 1 lock, 2 low supply; changed just after an edge
   task automatic set_pin(input int which, input logic v);
      @(posedge clk_in);
      case (which)
         0: receive_on_ctrl_out <= v;
         1: lock_out <= v;
         default: supply_low_out <= v;
      endcase
   endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pas_pkg::*;
   // short counts keep the run brief; the settle and enable windows derive from these, the shift and drop windows from the package
   localparam int SETTLE = 2000;
   localparam int PA_ENABLE_OUT   = 10;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic [5:0]  src = 6'h00;
   logic        receive_on_ctrl, lock, low, aux_pin;
   logic        pa, dout, aux_out, aux_oe, shift, rxm;
   logic [1:0]  route;
   logic [2:0]  ats;
   logic [31:0] d;
   int          err_total = 0;
   int          n_compared = 0;
   int          n, m;

   always #2 clk = ~clk;

   pas_far_model u_far (.clk_in(clk), .aux_oe_in(aux_oe), .aux_drv_in(aux_out),
      .receive_on_ctrl_out(receive_on_ctrl), .lock_out(lock), .supply_low_out(low), .aux_pin_out(aux_pin));

   pas_sequencer #(.SETTLE_CYCLES(SETTLE), .PA_ON_CYCLES(PA_ENABLE_OUT)) u_dut (
      .core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .receive_on_ctrl_in(receive_on_ctrl), .synth_lock_in(lock), .supply_low_in(low),
      .aux_analog_pin_in(aux_pin), .rx_data_in(src[0]), .agc_state_in(src[1]),
      .main_div_in(src[2]), .ref_div_in(src[3]), .sd_lsb_in(src[4]), .sd_msb_in(src[5]),
      .pa_enable_out(pa), .dout_out(dout), .aux_analog_pin_out(aux_out),
      .aux_analog_pin_oe_out(aux_oe), .aux_route_out(route),
      .analog_test_select_out(ats), .synth_shift_rx_out(shift), .rx_mode_out(rxm));

   task automatic stop_test;
      if (err_total == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", nm, e, g);
         err_total++;
      end
   endtask

   task automatic rng(input string nm, input int lo, input int hi, input int g);
      n_compared++;
      if (g < lo || g > hi) begin
         $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
         err_total++;
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   function automatic logic sig(input int s);
      return (s == 0) ? pa : (s == 1) ? shift : rxm;
   endfunction

   // bounded wait on pa (0), shift (1) or rx mode (2); k counts edges waited
   task automatic wait_for(input int s, input logic v, input int lim, output int k);
      k = 0;
      while (sig(s) !== v && k < lim) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (sig(s) !== v) begin
         $display("BAD wait %0d exp %b got %b", s, v, sig(s));
         err_total++;
         stop_test;
      end
   endtask

   task automatic tx_slot;
      u_far.set_pin(0, 1'b0);
      wait_for(0, 1'b1, PA_ENABLE_OUT + 20, n);
      rng("pa_on_delay", PA_ENABLE_OUT + 2, PA_ENABLE_OUT + 6, n);
   endtask

   task automatic rx_slot;
      u_far.set_pin(0, 1'b1);
      wait_for(0, 1'b0, DROP_MAX_CYC, n);
      wait_for(1, 1'b1, SHIFT_CYC + 20, m);
      rng("shift_delay", SHIFT_CYC, SHIFT_CYC + 6, n + m);
      n = n + m;
      chk("rx_early", 0, rxm);
      wait_for(2, 1'b1, SETTLE, m);
      rng("rx_delay", SETTLE, SETTLE + 6, n + m);
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      stop_test;
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      chk("pa_rst", 0, pa);
      chk("route_rst", AUX_ROUTE_FILTER, route);
      wr_reg(8'h04, 32'hFFFF_FFFF);
      rd_reg(REG_CTRL_OFS, d);
      chk("ctrl_rst", 32'h0000_0010, d);
      rd_reg(REG_TEST_OFS, d);
      chk("test_rst", 32'h0, d);
      rd_reg(8'h04, d);
      chk("unmapped", 32'h0, d);
      tick(SETTLE + SHIFT_CYC);
      tx_slot();
      rd_reg(REG_STAT_OFS, d);
      chk("status_tx", 32'h0000_02B2, d);
      // lock lost in mid-slot, then at slot start
      u_far.set_pin(1, 1'b0);
      tick(6);
      chk("pa_unlock", 0, pa);
      u_far.set_pin(1, 1'b1);
      wait_for(0, 1'b1, 20, n);
      rx_slot();
      u_far.set_pin(1, 1'b0);
      u_far.set_pin(0, 1'b0);
      tick(PA_ENABLE_OUT * 3);
      chk("pa_nolock", 0, pa);
      u_far.set_pin(1, 1'b1);
      wait_for(0, 1'b1, 20, n);
      rx_slot();
      // power control written in receive, applied only at the next fall
      wr_reg(REG_CTRL_OFS, 32'h0000_0080);
      tick(4);
      chk("route_defer", AUX_ROUTE_FILTER, route);
      chk("oe_defer", 0, aux_oe);
      tx_slot();
      tick(2);
      chk("route_pwr", AUX_ROUTE_PWR, route);
      chk("oe_tpc1", 1, aux_oe);
      chk("aux_low", 0, aux_out);
      rd_reg(REG_STAT_OFS, d);
      chk("stat_aux", 3'b010, d[9:7]);
      wr_reg(REG_CTRL_OFS, 32'h0);
      tick(4);
      chk("oe_hold", 1, aux_oe);
      rx_slot();
      tx_slot();
      tick(2);
      chk("oe_tpc0", 0, aux_oe);
      wr_reg(REG_CTRL_OFS, 32'h0000_0010);
      rx_slot();
      tx_slot();
      tick(2);
      chk("route_back", AUX_ROUTE_FILTER, route);
      // low supply: ignored unless lockout is enabled, then latched
      u_far.set_pin(2, 1'b1);
      tick(6);
      chk("pa_nolvlo", 1, pa);
      u_far.set_pin(2, 1'b0);
      wr_reg(REG_CTRL_OFS, 32'h0000_0410);
      u_far.set_pin(2, 1'b1);
      tick(6);
      chk("pa_low_supply_lockout", 0, pa);
      u_far.set_pin(2, 1'b0);
      tick(PA_ENABLE_OUT * 3);
      chk("pa_latched", 0, pa);
      rd_reg(REG_STAT_OFS, d);
      chk("latch_set", 1, d[STAT_LOCKOUT]);
      rx_slot();
      rd_reg(REG_STAT_OFS, d);
      chk("latch_clr", 0, d[STAT_LOCKOUT]);
      tx_slot();
      // digital test routing, data out selections 0 to 3
      for (int s = 0; s < 4; s++) begin
         wr_reg(REG_TEST_OFS, 32'(s) << TEST_DTM_LSB);
         for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            src <= 6'(v) << s;
            tick(3);
            chk("dout_sel", v, dout);
            chk("pa_kept", 1, pa);
         end
      end
      wr_reg(REG_TEST_OFS, 32'(DTM_SD_MODE) << TEST_DTM_LSB);
      for (int v = 0; v < 4; v++) begin
         @(posedge clk);
         src <= 6'(v) << 4;
         tick(3);
         chk("pa_sd", v & 1, pa);
         chk("dout_sd", v >> 1, dout);
      end
      for (int a = 1; a < 8; a++) begin
         wr_reg(REG_TEST_OFS, 32'(a) << TEST_ATM_LSB);
         tick(3);
         chk("route_atm", AUX_ROUTE_TEST, route);
         chk("atm_sel", a, ats);
         chk("oe_atm", 0, aux_oe);
      end
      wr_reg(REG_TEST_OFS, 32'h0);
      tick(3);
      chk("route_norm", AUX_ROUTE_FILTER, route);
      stop_test();
   end
endmodule
`default_nettype wire
